// [core/dcep_pkg.sv]
// constants, field layouts and carrier types of the dma channel enable / priority block
package dcep_pkg;
	localparam int NUM_CH = 4;
	// register byte offsets
	localparam logic [7:0] OFF_GLOBAL  = 8'h00;
	localparam logic [7:0] OFF_IRQ_ST  = 8'h04;
	localparam logic [7:0] OFF_IRQ_MSK = 8'h08;
	localparam logic [7:0] OFF_CTL0    = 8'h10;
	localparam logic [7:0] OFF_CNT0    = 8'h20;
	localparam logic [7:0] CH_STRIDE   = 8'h04;
	// global operation register fields
	localparam int GLB_W      = 16;
	localparam int GLB_DME    = 0;
	localparam int GLB_NMI_SEEN_FLAG   = 1;
	localparam int GLB_AE     = 2;
	localparam int GLB_PR_LO  = 8;
	localparam int GLB_PR_HI  = 9;
	// channel control register fields
	localparam int CTL_DE     = 0;
	localparam int CTL_TE     = 1;
	localparam int CTL_IE     = 2;
	localparam int CTL_SRC_LO = 8;
	localparam int CTL_SRC_HI = 11;
	// interrupt status layout
	localparam int IST_AE     = 4;
	localparam int IST_NMI    = 5;
	localparam int IST_W      = 6;
	// request source codes
	localparam logic [3:0] SRC_AUTO = 4'h0;
	localparam logic [3:0] SRC_PIN  = 4'h1;
	// priority codes
	localparam logic [1:0] PR_FIXED = 2'h0;
	localparam logic [1:0] PR_ALT_A = 2'h1;
	localparam logic [1:0] PR_ALT_B = 2'h2;
	localparam logic [1:0] PR_RR    = 2'h3;
	// service orders, highest priority in the low two bits
	localparam logic [7:0] ORDER_FIXED = 8'hE4; // 0,1,2,3
	localparam logic [7:0] ORDER_ALT_A = 8'h78; // 0,2,3,1
	localparam logic [7:0] ORDER_ALT_B = 8'hD2; // 2,0,1,3
	localparam logic [31:0] RST_WORD   = 32'h0000_0000;

	typedef struct packed {
		logic [3:0] src;
		logic       ie;
		logic       te;
		logic       de;
	} dcep_chctl_t;

	typedef struct packed {
		logic [1:0] pr;
		logic       ae;
		logic       nmi_seen_flag;
		logic       global_dma_enable;
	} dcep_glob_t;

	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} dcep_apb_req_t;
endpackage : dcep_pkg

// [core/dcep_top.sv]
// four channel dma enable, end flag, error flags and priority arbiter with apb registers
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
module dcep_top #(
	parameter int CNT_W = 24
) (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [7:0]                 paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic [1:0]                 dreq_pin_n,
	input  wire logic [dcep_pkg::NUM_CH-1:0] periph_req,
	input  wire logic                       nmi_pin,
	input  wire logic                       addr_err,
	input  wire logic                       standby_entry,
	input  wire logic                       xfer_done,
	output logic      [dcep_pkg::NUM_CH-1:0] xfer_grant,
	output logic      [dcep_pkg::NUM_CH-1:0] chan_irq,
	output logic                            irq
);
	localparam int N = dcep_pkg::NUM_CH;

	dcep_pkg::dcep_apb_req_t  req;
	dcep_pkg::dcep_chctl_t    ctl_r [N];
	dcep_pkg::dcep_glob_t     glb_r;
	logic [CNT_W-1:0]         cnt_r [N];
	logic [N-1:0]             te_seen_r;
	logic                     ae_seen_r;
	logic                     nmi_seen_r;
	logic [N-1:0]             pend_r;
	logic [N-1:0]             ok;
	logic [N-1:0]             want;
	logic [N-1:0]             grant_r;
	logic [N-1:0]             pick;
	logic [N-1:0]             te_set;
	logic [1:0]               last_r;
	logic [1:0]               pin_s1_r;
	logic [1:0]               pin_s2_r;
	logic [1:0]               pin_d_r;
	logic [1:0]               pin_fall;
	logic                     nmi_s1_r;
	logic                     nmi_s2_r;
	logic                     nmi_d_r;
	logic                     nmi_rise;
	logic [dcep_pkg::IST_W-1:0] ist_r;
	logic [dcep_pkg::IST_W-1:0] imsk_r;
	logic                     acc;
	logic                     wr_en;
	logic                     rd_setup;
	logic                     glb_hit;
	logic                     ist_hit;
	logic                     imsk_hit;
	logic [N-1:0]             ctl_hit;
	logic [N-1:0]             cnt_hit;
	logic                     mapped;
	logic [31:0]              rd_word;
	logic                     pready_r;
	logic [31:0]              prdata_r;
	logic                     pslverr_r;
	logic [N-1:0]             chan_irq_r;
	logic                     irq_r;

	// bundle the bus request
	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

	// address decode, one word per register
	assign glb_hit  = req.paddr == dcep_pkg::OFF_GLOBAL;
	assign ist_hit  = req.paddr == dcep_pkg::OFF_IRQ_ST;
	assign imsk_hit = req.paddr == dcep_pkg::OFF_IRQ_MSK;
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_dec
			localparam logic [7:0] IDX = 8'(gi);
			assign ctl_hit[gi] = req.paddr == dcep_pkg::OFF_CTL0 + IDX * dcep_pkg::CH_STRIDE;
			assign cnt_hit[gi] = req.paddr == dcep_pkg::OFF_CNT0 + IDX * dcep_pkg::CH_STRIDE;
		end
	endgenerate
	assign mapped   = glb_hit | ist_hit | imsk_hit | (|ctl_hit) | (|cnt_hit);
	assign rd_setup = req.psel & ~req.penable;
	assign acc      = req.psel & req.penable & pready_r;
	assign wr_en    = acc & req.pwrite & mapped;

	// read mux, unused and reserved bits read zero
	always_comb begin
		rd_word = dcep_pkg::RST_WORD;
		if (glb_hit) begin
			rd_word[dcep_pkg::GLB_PR_HI:dcep_pkg::GLB_PR_LO] = glb_r.pr;
			rd_word[dcep_pkg::GLB_AE]   = glb_r.ae;
			rd_word[dcep_pkg::GLB_NMI_SEEN_FLAG] = glb_r.nmi_seen_flag;
			rd_word[dcep_pkg::GLB_DME]  = glb_r.global_dma_enable;
		end
		if (ist_hit) begin
			rd_word[dcep_pkg::IST_W-1:0] = ist_r;
		end
		if (imsk_hit) begin
			rd_word[dcep_pkg::IST_W-1:0] = imsk_r;
		end
		for (int i = 0; i < N; i++) begin
			if (ctl_hit[i]) begin
				rd_word[dcep_pkg::CTL_SRC_HI:dcep_pkg::CTL_SRC_LO] = ctl_r[i].src;
				rd_word[dcep_pkg::CTL_IE] = ctl_r[i].ie;
				rd_word[dcep_pkg::CTL_TE] = ctl_r[i].te;
				rd_word[dcep_pkg::CTL_DE] = ctl_r[i].de;
			end
			if (cnt_hit[i]) begin
				rd_word[CNT_W-1:0] = cnt_r[i];
			end
		end
	end

	// apb answer: no wait state, pready raised in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			prdata_r  <= dcep_pkg::RST_WORD;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= rd_setup;
			pslverr_r <= rd_setup & ~mapped;
			if (rd_setup) begin
				prdata_r <= req.pwrite ? dcep_pkg::RST_WORD : rd_word;
			end
		end
	end

	// pin synchronisers, first stage read only by the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_r <= 2'h3;
			pin_s2_r <= 2'h3;
			pin_d_r  <= 2'h3;
			nmi_s1_r <= 1'b0;
			nmi_s2_r <= 1'b0;
			nmi_d_r  <= 1'b0;
		end else begin
			pin_s1_r <= dreq_pin_n;
			pin_s2_r <= pin_s1_r;
			pin_d_r  <= pin_s2_r;
			nmi_s1_r <= nmi_pin;
			nmi_s2_r <= nmi_s1_r;
			nmi_d_r  <= nmi_s2_r;
		end
	end
	assign pin_fall = pin_d_r & ~pin_s2_r;
	assign nmi_rise = nmi_s2_r & ~nmi_d_r;

	// global operation register and its error flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			glb_r      <= '0;
			ae_seen_r  <= 1'b0;
			nmi_seen_r <= 1'b0;
		end else begin
			if (acc && !req.pwrite && glb_hit) begin
				ae_seen_r  <= glb_r.ae;
				nmi_seen_r <= glb_r.nmi_seen_flag;
			end
			if (wr_en && glb_hit) begin
				glb_r.pr  <= req.pwdata[dcep_pkg::GLB_PR_HI:dcep_pkg::GLB_PR_LO];
				glb_r.global_dma_enable <= req.pwdata[dcep_pkg::GLB_DME];
				if (ae_seen_r && !req.pwdata[dcep_pkg::GLB_AE]) begin
					glb_r.ae  <= 1'b0;
					ae_seen_r <= 1'b0;
				end
				if (nmi_seen_r && !req.pwdata[dcep_pkg::GLB_NMI_SEEN_FLAG]) begin
					glb_r.nmi_seen_flag <= 1'b0;
					nmi_seen_r <= 1'b0;
				end
			end
			if (addr_err) begin
				glb_r.ae <= 1'b1;
			end
			if (nmi_rise) begin
				glb_r.nmi_seen_flag <= 1'b1;
			end
		end
	end

	// which channels may run at all
	generate
		for (gi = 0; gi < N; gi++) begin : g_ok
			assign ok[gi] = ctl_r[gi].de & ~ctl_r[gi].te & glb_r.global_dma_enable & ~glb_r.ae & ~glb_r.nmi_seen_flag;
			assign want[gi] = ok[gi] & (ctl_r[gi].src == dcep_pkg::SRC_AUTO | pend_r[gi]);
			assign te_set[gi] = grant_r[gi] & xfer_done & ok[gi] & (cnt_r[gi] == CNT_W'(1));
		end
	endgenerate

	// channel control, count and end flag per channel
	generate
		for (gi = 0; gi < N; gi++) begin : g_ch
			logic ext_ev;
			logic wr_ctl;
			assign wr_ctl = wr_en & ctl_hit[gi];
			if (gi < 2) begin : g_pin
				assign ext_ev = (ctl_r[gi].src == dcep_pkg::SRC_PIN) ? pin_fall[gi] : periph_req[gi];
			end else begin : g_mod
				assign ext_ev = periph_req[gi];
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ctl_r[gi]     <= '0;
					te_seen_r[gi] <= 1'b0;
				end else begin
					if (acc && !req.pwrite && ctl_hit[gi]) begin
						te_seen_r[gi] <= ctl_r[gi].te;
					end
					if (wr_ctl) begin
						ctl_r[gi].de  <= req.pwdata[dcep_pkg::CTL_DE];
						ctl_r[gi].ie  <= req.pwdata[dcep_pkg::CTL_IE];
						ctl_r[gi].src <= req.pwdata[dcep_pkg::CTL_SRC_HI:dcep_pkg::CTL_SRC_LO];
						if (te_seen_r[gi] && !req.pwdata[dcep_pkg::CTL_TE]) begin
							ctl_r[gi].te  <= 1'b0;
							te_seen_r[gi] <= 1'b0;
						end
					end
					if (standby_entry) begin
						ctl_r[gi].te <= 1'b0;
					end
					if (te_set[gi]) begin
						ctl_r[gi].te <= 1'b1;
					end
				end
			end
			// request latch, only events after enable are kept
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pend_r[gi] <= 1'b0;
				end else if (!ctl_r[gi].de) begin
					pend_r[gi] <= 1'b0;
				end else if (ext_ev) begin
					pend_r[gi] <= 1'b1;
				end else if (grant_r[gi] && xfer_done) begin
					pend_r[gi] <= 1'b0;
				end
			end
			// remaining transfer count, loaded by software
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt_r[gi] <= '0;
				end else if (wr_en && cnt_hit[gi]) begin
					cnt_r[gi] <= req.pwdata[CNT_W-1:0];
				end else if (grant_r[gi] && xfer_done && ok[gi] && cnt_r[gi] != '0) begin
					cnt_r[gi] <= cnt_r[gi] - CNT_W'(1);
				end
			end
		end
	endgenerate

	// priority pick over the requesting channels
	always_comb begin
		logic [7:0] order;
		logic       found;
		logic [1:0] ch;
		order = dcep_pkg::ORDER_FIXED;
		found = 1'b0;
		ch    = 2'h0;
		pick  = '0;
		unique case (glb_r.pr)
			dcep_pkg::PR_FIXED: order = dcep_pkg::ORDER_FIXED;
			dcep_pkg::PR_ALT_A: order = dcep_pkg::ORDER_ALT_A;
			dcep_pkg::PR_ALT_B: order = dcep_pkg::ORDER_ALT_B;
			dcep_pkg::PR_RR: order = {last_r + 2'h0, last_r + 2'h3, last_r + 2'h2, last_r + 2'h1};
		endcase
		for (int k = 0; k < N; k++) begin
			ch = order[2*k +: 2];
			if (!found && want[ch]) begin
				pick[ch] = 1'b1;
				found    = 1'b1;
			end
		end
	end

	// grant holder: one channel at a time, dropped when it may no longer run
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			grant_r <= '0;
			last_r  <= 2'h3;
		end else if (grant_r == '0) begin
			grant_r <= pick;
			for (int i = 0; i < N; i++) begin
				if (pick[i]) begin
					last_r <= 2'(i);
				end
			end
		end else if ((grant_r & ok) == '0) begin
			grant_r <= '0;
		end else if (xfer_done) begin
			grant_r <= '0;
		end
	end
	assign xfer_grant = grant_r;

	// sticky interrupt status, write one to clear, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ist_r  <= '0;
			imsk_r <= '0;
		end else begin
			if (wr_en && imsk_hit) begin
				imsk_r <= req.pwdata[dcep_pkg::IST_W-1:0];
			end
			ist_r <= (ist_r & ~((wr_en && ist_hit) ? req.pwdata[dcep_pkg::IST_W-1:0] : '0))
			         | {nmi_rise, addr_err, te_set};
		end
	end

	// interrupt outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_irq_r <= '0;
			irq_r      <= 1'b0;
		end else begin
			for (int i = 0; i < N; i++) begin
				chan_irq_r[i] <= ctl_r[i].te & ctl_r[i].ie;
			end
			irq_r <= |(ist_r & imsk_r);
		end
	end

	assign chan_irq = chan_irq_r;
	assign irq      = irq_r;
	assign prdata   = prdata_r;
	assign pready   = pready_r;
	assign pslverr  = pslverr_r;
endmodule : dcep_top

// [dv/dcep_dpath_model.sv]
// data path stand-in: answers each grant with one done pulse, fast or slow
`timescale 1ns/1ps
module dcep_dpath_model (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic [3:0] xfer_grant,
	input wire logic       slow,
	output logic           xfer_done
);
	logic [3:0] cnt_r;

	// count granted cycles, pulse done once, then clear the count and start again while the grant is held
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r     <= 4'h0;
			xfer_done <= 1'h0;
		end else if (xfer_grant == 4'h0 || xfer_done) begin
			cnt_r     <= 4'h0;
			xfer_done <= 1'h0;
		end else begin
			cnt_r     <= cnt_r + 4'h1;
			xfer_done <= (cnt_r == (slow ? 4'hE : 4'h1));
		end
	end
endmodule : dcep_dpath_model

// [dv/dcep_top_sva.sv]
// concurrent checks on the apb, grant and interrupt ports of dcep_top
`timescale 1ns/1ps
module dcep_top_sva (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       nmi_pin,
	input wire logic       addr_err,
	input wire logic       standby_entry,
	input wire logic       xfer_done,
	input wire logic [3:0] xfer_grant,
	input wire logic [3:0] chan_irq
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// apb setup cycle, and a stretch with no channel granted
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_idle4;
		(xfer_grant == 4'h0) [*4];
	endsequence

	setup_ready_a: assert property (s_setup |=> pready)
		else $error("no access cycle after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr outside access cycle");
	grant_onehot_a: assert property ($onehot0(xfer_grant))
		else $error("more than one channel granted");
	done_drops_a: assert property (xfer_done && xfer_grant != 4'h0 |=> xfer_grant == 4'h0)
		else $error("grant kept after done");
	ae_halts_a: assert property (addr_err |-> ##2 s_idle4)
		else $error("grant after address error");
	nmi_halts_a: assert property ($rose(nmi_pin) |-> ##[2:5] xfer_grant == 4'h0)
		else $error("grant after nmi");
	standby_clr_a: assert property (standby_entry && !xfer_done |-> ##2 chan_irq == 4'h0)
		else $error("end flag kept in standby");
endmodule : dcep_top_sva

// [dv/dcep_top_test.sv]
// self-checking bench for dcep_top
`timescale 1ns/1ps
module dcep_top_test;
	localparam logic [7:0] a_glb = dcep_pkg::OFF_GLOBAL;
	localparam logic [7:0] a_ist = dcep_pkg::OFF_IRQ_ST;
	localparam logic [7:0] a_msk = dcep_pkg::OFF_IRQ_MSK;
	localparam logic [7:0] a_ctl = dcep_pkg::OFF_CTL0;
	localparam logic [7:0] a_cnt = dcep_pkg::OFF_CNT0;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slv_q;
	logic        nmi_pin, addr_err, standby_entry, xfer_done, slow;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd_q;
	logic [3:0]  periph_req, xfer_grant, chan_irq;
	logic [1:0]  dreq_pin_n;
	int          n_fail, n_checks;

	dcep_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .dreq_pin_n(dreq_pin_n), .periph_req(periph_req),
		.nmi_pin(nmi_pin), .addr_err(addr_err), .standby_entry(standby_entry),
		.xfer_done(xfer_done), .xfer_grant(xfer_grant), .chan_irq(chan_irq), .irq(irq));
	dcep_dpath_model u_dp (.pclk(pclk), .presetn(presetn), .xfer_grant(xfer_grant),
		.slow(slow), .xfer_done(xfer_done));

	// 4 ns clock
	always #2 pclk = ~pclk;

	task automatic end_of_test;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test

	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, exp, got);
		end
	endtask : chk

	// one apb transfer, held until pready, then one idle cycle
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd_q = prdata;
		slv_q = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : apb

	task automatic wt(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask : wt

	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(n, rd_q, e);
	endtask : rd

	// wait for a done pulse and name the granted channel
	task automatic next_done(output int c);
		int k;
		k = 0;
		while (!(xfer_done === 1'h1 && xfer_grant !== 4'h0) && k < 200) begin
			@(posedge pclk);
			k++;
		end
		c = 9;
		for (int i = 0; i < 4; i++)
			if (xfer_grant[i] === 1'h1) c = i;
		@(posedge pclk);
	endtask : next_done

	task automatic t_regs;
		rd("glb_rst", a_glb, 32'h0);
		rd("ctl_rst", a_ctl, 32'h0);
		wt(a_glb, 32'h0000_0307);
		rd("glb_rw", a_glb, 32'h0000_0301);
		wt(a_ctl, 32'h0000_0002);
		rd("te_w1", a_ctl, 32'h0);
		rd("unmapped", 8'hFC, 32'h0);
		chk("slverr", {31'h0, slv_q}, 32'h1);
	endtask : t_regs

	task automatic t_end;
		int c;
		wt(a_msk, 32'h1);
		wt(a_cnt, 32'h2);
		wt(a_glb, 32'h1);
		wt(a_ctl, 32'h5);
		next_done(c);
		chk("auto_a", c, 0);
		next_done(c);
		chk("auto_b", c, 0);
		repeat (3) @(posedge pclk);
		chk("te_block", xfer_grant, 32'h0);
		chk("chan_irq", chan_irq, 32'h1);
		chk("irq", irq, 32'h1);
		rd("te_set", a_ctl, 32'h7);
		wt(a_ctl, 32'h4);
		rd("te_clr", a_ctl, 32'h4);
		wt(a_ist, 32'h1);
		@(posedge pclk);
		chk("irq_clr", irq, 32'h0);
	endtask : t_end

	task automatic t_prio;
		int c, p;
		logic [7:0] ord [3];
		ord = '{8'hE4, 8'h78, 8'hD2};
		wt(a_msk, 32'h0);
		for (int m = 0; m < 4; m++) begin
			wt(a_glb, {22'h0, m[1:0], 8'h00});
			for (int k = 0; k < 4; k++) begin
				wt(a_cnt + 8'(4 * k), (m == 3) ? 32'h2 : 32'h1);
				wt(a_ctl + 8'(4 * k), 32'h1);
			end
			wt(a_glb, {22'h0, m[1:0], 8'h01});
			for (int k = 0; k < ((m == 3) ? 8 : 4); k++) begin
				next_done(c);
				if (m == 3 && k > 0)
					chk("rr_next", c, (p + 1) % 4);
				else if (m < 3)
					chk("order", c, ord[m][2 * k +: 2]);
				p = c;
			end
			chk("irq_mask", irq, 32'h0);
			wt(a_glb, 32'h0);
			standby_entry <= 1'h1;
			@(posedge pclk);
			standby_entry <= 1'h0;
			for (int k = 0; k < 4; k++) begin
				rd("standby", a_ctl + 8'(4 * k), 32'h1);
				wt(a_ctl + 8'(4 * k), 32'h0);
			end
			wt(a_ist, 32'h0000_003F);
		end
	endtask : t_prio

	task automatic t_stop;
		slow <= 1'h1;
		wt(a_glb, 32'h1);
		wt(a_cnt + 8'h04, 32'h5);
		wt(a_ctl + 8'h04, 32'h1);
		repeat (3) @(posedge pclk);
		chk("grant1", xfer_grant, 32'h2);
		wt(a_ctl + 8'h04, 32'h0);
		repeat (2) @(posedge pclk);
		chk("de_susp", xfer_grant, 32'h0);
		rd("no_te", a_ctl + 8'h04, 32'h0);
		wt(a_ctl + 8'h04, 32'h1);
		repeat (3) @(posedge pclk);
		addr_err <= 1'h1;
		@(posedge pclk);
		addr_err <= 1'h0;
		repeat (3) @(posedge pclk);
		chk("ae_susp", xfer_grant, 32'h0);
		rd("ae_flag", a_glb, 32'h5);
		wt(a_glb, 32'h1);
		nmi_pin <= 1'h1;
		repeat (8) @(posedge pclk);
		nmi_pin <= 1'h0;
		chk("nmi_susp", xfer_grant, 32'h0);
		rd("nmi_flag", a_glb, 32'h3);
		wt(a_glb, 32'h1);
		repeat (2) @(posedge pclk);
		chk("resume", xfer_grant, 32'h2);
		wt(a_ctl + 8'h04, 32'h0);
		slow <= 1'h0;
	endtask : t_stop

	task automatic t_req;
		int c;
		wt(a_cnt + 8'h08, 32'h1);
		wt(a_ctl + 8'h08, 32'h0000_0200);
		periph_req <= 4'h4;
		@(posedge pclk);
		periph_req <= 4'h0;
		wt(a_ctl + 8'h08, 32'h0000_0201);
		repeat (4) @(posedge pclk);
		chk("early_req", xfer_grant, 32'h0);
		periph_req <= 4'h4;
		@(posedge pclk);
		periph_req <= 4'h0;
		repeat (2) @(posedge pclk);
		chk("req_grant", xfer_grant, 32'h4);
		next_done(c);
		rd("te_req", a_ctl + 8'h08, 32'h0000_0203);
		wt(a_ctl + 8'h08, 32'h0);
	endtask : t_req

	// external pin request on channel 0: only a falling edge after enable counts
	task automatic t_pin;
		int c;
		wt(a_cnt, 32'h1);
		wt(a_ctl, 32'h0000_0101);
		repeat (4) @(posedge pclk);
		chk("pin_idle", xfer_grant, 32'h0);
		dreq_pin_n <= 2'h2;
		next_done(c);
		chk("pin_grant", c, 0);
		rd("te_pin", a_ctl, 32'h0000_0103);
		dreq_pin_n <= 2'h3;
		wt(a_ctl, 32'h0);
	endtask : t_pin

	// reset, then the scenarios in turn
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{periph_req, nmi_pin, addr_err, standby_entry, slow} = '0;
		dreq_pin_n = 2'h3;
		n_fail = 0;
		n_checks = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_regs();
		t_end();
		t_prio();
		t_stop();
		t_req();
		t_pin();
		end_of_test();
	end

	// watchdog against a hung wait
	initial begin
		repeat (5000) @(posedge pclk);
		n_fail++;
		end_of_test();
	end
endmodule : dcep_top_test

bind dcep_top dcep_top_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .nmi_pin(nmi_pin),
	.addr_err(addr_err), .standby_entry(standby_entry), .xfer_done(xfer_done),
	.xfer_grant(xfer_grant), .chan_irq(chan_irq));
